// *** inc/cwwp_regs.vh ***
// register map and field layout of the config word protection block
// assumes a 32-bit classic wishbone slave and a 24-bit program address
`ifndef CWWP_REGS_VH
`define CWWP_REGS_VH
// register byte offsets
`define CWWP_OFF_CW3 4'h0
`define CWWP_OFF_CW4 4'h4
`define CWWP_OFF_STAT 4'h8
`define CWWP_OFF_CTRL 4'hC
// fields of configuration word three
`define CWWP_BOUNDARY_DIRECTION 15
`define CWWP_CONFIG_PAGE_PROTECT_N 14
`define CWWP_SEGMENT_PROTECT_DISABLE 13
`define CWWP_PARALLEL_PORT_PIN_MAP 12
`define CWWP_WAKE_HI 11
`define CWWP_WAKE_LO 10
`define CWWP_SECONDARY_OSCILLATOR_HI 9
`define CWWP_SECONDARY_OSCILLATOR_LO 8
`define CWWP_PAGE_HI 7
`define CWWP_PAGE_LO 0
// codes of the two-bit selects
`define CWWP_WAKE_DEFAULT 2'h3
`define CWWP_WAKE_FAST 2'h1
`define CWWP_SECONDARY_OSCILLATOR_HIGH 2'h3
`define CWWP_SECONDARY_OSCILLATOR_RSVD 2'h2
`define CWWP_SECONDARY_OSCILLATOR_LOW 2'h1
`define CWWP_SECONDARY_OSCILLATOR_EXT 2'h0
// unimplemented upper bytes and erased values
`define CWWP_CW3_UPPER 8'hFF
`define CWWP_CW4_UPPER 8'h00
`define CWWP_ERASED 16'hFFFF
// page of 512 instruction words spans 1024 address units
`define CWWP_PAGE_SHIFT 10
// status bits
`define CWWP_ST_REJECT 0
`define CWWP_ST_WAKE_RSVD 1
`define CWWP_ST_SECONDARY_OSCILLATOR_RSVD 2
`define CWWP_ST_CFG_PROT 3
`define CWWP_ST_ENABLED 4
`define CWWP_ST_LO_LSB 8
`define CWWP_ST_HI_LSB 16
`define CWWP_ST_REJ_LSB 24
// control bits and start-up synchroniser length
`define CWWP_CTRL_CLR_REJECT 0
`define CWWP_SYNC_CYCLES 2'h2
`endif

// *** src/cwwp_top.v ***
// config word decode and segmented flash write protection
// assumes fuse values are static, flash requests on clk_i
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "cwwp_regs.vh"
module cwwp_top #(
  parameter ADDR_W = 24,
  parameter [7:0] LAST_PAGE = 8'hFF,
  parameter PIN64 = 0
) (
  input wire clk_i,
  input wire rst_i,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // nonvolatile fuse image, from outside the clock domain
  input wire [15:0] nv_cw3_i,
  input wire [15:0] nv_cw4_i,
  // one-time programming of word three
  output reg cw3_prog_o,
  output reg [15:0] cw3_prog_data_o,
  // flash write controller requests
  input wire fl_req_i,
  input wire [ADDR_W-1:0] fl_addr_i,
  output reg fl_ok_o,
  output reg fl_reject_o,
  // regulator standby allowed, from the reset controller
  input wire reg_standby_en_i,
  // decoded configuration
  output reg ready_o,
  output reg pmp_default_map_o,
  output reg wake_fast_o,
  output reg secondary_oscillator_high_drive_o,
  output reg secondary_oscillator_low_power_o,
  output reg secondary_oscillator_ext_o
);

  localparam [2:0] ST_SYNC = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  // synchroniser stages, one pair per fuse word
  reg [15:0] cw3_m_ff;
  reg [15:0] cw3_s_ff;
  reg [15:0] cw4_m_ff;
  reg [15:0] cw4_s_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] cnt_ff;
  // latched words, program image, window bounds and flags
  reg [15:0] cw3_ff;
  reg [15:0] cw4_ff;
  reg [15:0] img_ff;
  reg [7:0] lo_ff;
  reg [7:0] hi_ff;
  reg en_ff;
  reg cfg_prot_ff;
  reg reject_ff;
  reg [7:0] rej_page_ff;

  // two-flop synchroniser for the fuse image
  // image is quasi-static; only the settled copy is ever latched
  always @(posedge clk_i) begin
    cw3_m_ff <= nv_cw3_i;
    cw3_s_ff <= cw3_m_ff;
    cw4_m_ff <= nv_cw4_i;
    cw4_s_ff <= cw4_m_ff;
  end

  // timeline after release: count runs 0..2 while the synchroniser
  // flushes, one edge latches the words, then run; ready_o and the
  // window bounds follow one edge after run is entered
  // start-up sequencer: settle synchroniser, then latch once
  always @* begin
    case (state_ff)
      ST_SYNC: nxt_state = (cnt_ff == `CWWP_SYNC_CYCLES) ?
                           ST_LOAD : ST_SYNC;
      ST_LOAD: nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_SYNC;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_SYNC;
      cnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_SYNC)
        cnt_ff <= cnt_ff + 2'h1;
    end
  end

  // latched words: taken once after reset, never while running
  always @(posedge clk_i) begin
    if (rst_i) begin
      cw3_ff <= `CWWP_ERASED;
      cw4_ff <= `CWWP_ERASED;
    end else if (state_ff == ST_LOAD) begin
      cw3_ff <= cw3_s_ff;
      cw4_ff <= cw4_s_ff;
    end
  end

  wire dir = cw3_ff[`CWWP_BOUNDARY_DIRECTION];
  wire cfgp_n = cw3_ff[`CWWP_CONFIG_PAGE_PROTECT_N];
  wire dis = cw3_ff[`CWWP_SEGMENT_PROTECT_DISABLE];
  wire [7:0] bpage = cw3_ff[`CWWP_PAGE_HI:`CWWP_PAGE_LO];
  wire [1:0] wake = cw3_ff[`CWWP_WAKE_HI:`CWWP_WAKE_LO];
  wire [1:0] secondary_oscillator = cw3_ff[`CWWP_SECONDARY_OSCILLATOR_HI:`CWWP_SECONDARY_OSCILLATOR_LO];
  // 64-pin parts have no map bit; it then reads as set
  wire pmap = cw3_ff[`CWWP_PARALLEL_PORT_PIN_MAP] | (PIN64 != 0);

  // window decode, registered so checks see stable bounds
  // both bounds are inclusive pages; with the disable bit set the
  // enable stays low and the bounds are never looked at
  always @(posedge clk_i) begin
    if (rst_i) begin
      lo_ff <= 8'h00;
      hi_ff <= LAST_PAGE;
      en_ff <= 1'b0;
      cfg_prot_ff <= 1'b0;
    end else if (state_ff == ST_RUN) begin
      en_ff <= ~dis;
      lo_ff <= dir ? bpage : 8'h00;
      hi_ff <= dir ? LAST_PAGE : bpage;
      // override wins over the open setting of the protect bit
      cfg_prot_ff <= ~dis & (~cfgp_n | dir |
                     (bpage == LAST_PAGE));
    end
  end

  // page of the requested address; config words share last page
  wire [7:0] req_page =
    fl_addr_i[`CWWP_PAGE_SHIFT +: 8];
  // addresses past the last page never fall in the window
  wire above = |(fl_addr_i >> (`CWWP_PAGE_SHIFT + 8));
  wire in_seg = en_ff & ~above &
                (req_page >= lo_ff) & (req_page <= hi_ff);
  wire in_cfg = cfg_prot_ff & ~above & (req_page == LAST_PAGE);
  wire run = (state_ff == ST_RUN);

  // bounds are valid from the edge that raises ready_o; in the one
  // cycle where run is set but the bounds are not, requests and
  // word three writes are refused so nothing slips through
  wire live = ready_o;

  // wishbone decode; ack for one cycle, then dropped
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_cw3 = wb_hit & wb_we_i & (wb_adr_i == `CWWP_OFF_CW3);
  wire wr_ctrl = wb_hit & wb_we_i & (wb_adr_i == `CWWP_OFF_CTRL);
  wire clr_rej = wr_ctrl & wb_sel_i[0] &
                 wb_dat_i[`CWWP_CTRL_CLR_REJECT];
  // upper byte lanes carry nothing writable
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // config words live in the last page: same guard applies
  wire cw3_blocked = ~live | cfg_prot_ff;

  // flash request answer: ok or reject one cycle later
  always @(posedge clk_i) begin
    if (rst_i) begin
      fl_ok_o <= 1'b0;
      fl_reject_o <= 1'b0;
    end else begin
      fl_ok_o <= fl_req_i & live & ~in_seg & ~in_cfg;
      // no request passes before the window is known;
      // refusing is the safe failure for a protection block,
      // so exactly one of the two answers is pulsed
      fl_reject_o <= fl_req_i & (~live | in_seg | in_cfg);
    end
  end

  // sticky reject flag; a new reject beats the clear
  // page field keeps the last refused page for software
  always @(posedge clk_i) begin
    if (rst_i) begin
      reject_ff <= 1'b0;
      rej_page_ff <= 8'h00;
    end else begin
      if (fl_req_i & (~live | in_seg | in_cfg)) begin
        reject_ff <= 1'b1;
        rej_page_ff <= req_page;
      end else if (wr_cw3 & cw3_blocked) begin
        reject_ff <= 1'b1;
        rej_page_ff <= LAST_PAGE;
      end else if (clr_rej) begin
        reject_ff <= 1'b0;
      end
    end
  end

  // program image: bits only go from one to zero, once
  // the new image only reaches the fuse store; the decode keeps
  // the latched word until the next reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      img_ff <= `CWWP_ERASED;
      cw3_prog_o <= 1'b0;
      cw3_prog_data_o <= `CWWP_ERASED;
    end else begin
      if (state_ff == ST_LOAD)
        img_ff <= cw3_s_ff;
      cw3_prog_o <= wr_cw3 & ~cw3_blocked;
      if (wr_cw3 & ~cw3_blocked) begin
        // a programmed zero cannot return to one
        img_ff <= img_ff & (wb_dat_i[15:0] | ~wmask);
        cw3_prog_data_o <= img_ff & (wb_dat_i[15:0] | ~wmask);
      end
    end
  end

  // decoded side outputs, stable once running except wake_fast_o, which follows reg_standby_en_i
  // pmap already carries the 64-pin forcing of the map bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      pmp_default_map_o <= 1'b1;
      wake_fast_o <= 1'b0;
      secondary_oscillator_high_drive_o <= 1'b0;
      secondary_oscillator_low_power_o <= 1'b0;
      secondary_oscillator_ext_o <= 1'b0;
    end else if (run) begin
      ready_o <= 1'b1;
      pmp_default_map_o <= pmap;
      // fast wake only counts when standby is allowed
      wake_fast_o <= reg_standby_en_i &
                     (wake == `CWWP_WAKE_FAST);
      secondary_oscillator_high_drive_o <= (secondary_oscillator == `CWWP_SECONDARY_OSCILLATOR_HIGH);
      secondary_oscillator_low_power_o <= (secondary_oscillator == `CWWP_SECONDARY_OSCILLATOR_LOW);
      // pin must be a digital input in this mode
      secondary_oscillator_ext_o <= (secondary_oscillator == `CWWP_SECONDARY_OSCILLATOR_EXT);
    end
  end

  // read mux; unmapped offsets read zero
  // reserved select codes are flagged so software can spot a
  // mis-programmed word; the decode still maps them to safe outputs
  reg [31:0] rd_data;
  always @* begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `CWWP_OFF_CW3: rd_data = {8'h00, `CWWP_CW3_UPPER,
                                cw3_ff[15:13], pmap,
                                cw3_ff[11:0]};
      `CWWP_OFF_CW4: rd_data = {8'h00, `CWWP_CW4_UPPER,
                                cw4_ff};
      `CWWP_OFF_STAT: begin
        rd_data[`CWWP_ST_REJECT] = reject_ff;
        rd_data[`CWWP_ST_WAKE_RSVD] = ~wake[0];
        rd_data[`CWWP_ST_SECONDARY_OSCILLATOR_RSVD] =
          (secondary_oscillator == `CWWP_SECONDARY_OSCILLATOR_RSVD);
        rd_data[`CWWP_ST_CFG_PROT] = cfg_prot_ff;
        rd_data[`CWWP_ST_ENABLED] = en_ff;
        rd_data[`CWWP_ST_LO_LSB +: 8] = lo_ff;
        rd_data[`CWWP_ST_HI_LSB +: 8] = hi_ff;
        rd_data[`CWWP_ST_REJ_LSB +: 8] = rej_page_ff;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // bus answer registered, one wait state
  // a high ack masks the strobe, so a held request is not taken
  // twice; a next request can follow at once with stb held, no idle cycle needed
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit & ~wb_we_i)
        wb_dat_o <= rd_data;
    end
  end

endmodule

// *** bench/cwwp_fuse.sv ***
// fuse store for config words three and four
// assumes the bench loads an image while reset is held
`timescale 1ns/1ns
module cwwp_fuse #(
  parameter PIN64 = 0
) (
  input wire clk_i,
  input wire load_i,
  input wire [15:0] init_i,
  input wire prog_i,
  input wire [15:0] prog_data_i,
  output reg [15:0] cw3_o,
  output wire [15:0] cw4_o
);
  initial cw3_o = 16'hFFFF;
  // reserved word left erased by the programmer
  assign cw4_o = 16'hFFFF;
  // a burn only clears bits, so no bit comes back
  always @(posedge clk_i) begin
    if (load_i) begin
      // 64-pin images keep the absent map bit at one
      cw3_o <= init_i | {3'h0, PIN64 != 0, 12'h000};
    end else if (prog_i) begin
      cw3_o <= cw3_o & prog_data_i;
    end
  end
endmodule

// *** bench/cwwp_chk_asserts.sv ***
// port assertions for the protection block
// assumes one clock and a synchronous high reset
`timescale 1ns/1ns
module cwwp_chk (
  input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire wb_ack_o, cw3_prog_o, fl_req_i, fl_ok_o, fl_reject_o,
  input wire [15:0] nv_cw3_i, cw3_prog_data_o,
  input wire reg_standby_en_i, ready_o, pmp_default_map_o, wake_fast_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // start-up: sync cycles, then ready within a short span
  sequence s_hold;
    !ready_o [*3];
  endsequence
  sequence s_run;
    ##[0:2] ready_o;
  endsequence
  chk_ready_delay: assert property ($fell(rst_i) |-> s_hold ##1 s_run)
    else $error("ready late or early");
  chk_ready_held: assert property (ready_o |=> ready_o)
    else $error("ready dropped while running");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_fl_answer: assert property (fl_req_i |=> fl_ok_o != fl_reject_o)
    else $error("flash answer not one of two");
  chk_fl_quiet: assert property (!fl_req_i |=> !fl_ok_o && !fl_reject_o)
    else $error("flash answer without request");
  chk_prog_origin: assert property (cw3_prog_o |-> $past(wb_we_i)
    && $past(wb_stb_i) && $past(wb_adr_i) == 4'h0)
    else $error("burn without word three write");
  chk_prog_once: assert property (cw3_prog_o
    |-> (cw3_prog_data_o & ~nv_cw3_i) == 16'h0000)
    else $error("burn sets a cleared bit");
  chk_prog_pulse: assert property (cw3_prog_o |=> !cw3_prog_o)
    else $error("burn pulse too long");
  chk_wake_gate: assert property (wake_fast_o |-> $past(reg_standby_en_i))
    else $error("fast wake without standby");
  chk_reset_vals: assert property (disable iff (1'h0) rst_i |=> !ready_o
    && pmp_default_map_o && !wb_ack_o && !fl_ok_o && !cw3_prog_o)
    else $error("reset values wrong");
endmodule
bind cwwp_top cwwp_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .cw3_prog_o(cw3_prog_o),
  .fl_req_i(fl_req_i), .fl_ok_o(fl_ok_o), .fl_reject_o(fl_reject_o),
  .nv_cw3_i(nv_cw3_i), .cw3_prog_data_o(cw3_prog_data_o),
  .reg_standby_en_i(reg_standby_en_i), .ready_o(ready_o),
  .pmp_default_map_o(pmp_default_map_o), .wake_fast_o(wake_fast_o));

// *** bench/testbench.sv ***
// directed bench for the protection block with its fuse store
// assumes a 25 MHz clock; every task starts just after an edge
`timescale 1ns/1ns
module testbench;
  reg clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  reg wb_we_i = 1'h0, fl_req_i = 1'h0, reg_standby_en_i = 1'h1;
  reg ld = 1'h0, pg;
  reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h3;
  reg [31:0] wb_dat_i = 32'h0, rdat;
  reg [23:0] fl_addr_i = 24'h0;
  reg [15:0] init = 16'hFFFF;
  integer failures = 0, tests_run = 0;
  wire [31:0] wb_dat_o;
  wire [15:0] nv_cw3_i, nv_cw4_i, cw3_prog_data_o;
  wire wb_ack_o, cw3_prog_o, fl_ok_o, fl_reject_o, ready_o;
  wire pmp_default_map_o, wake_fast_o, secondary_oscillator_high_drive_o;
  wire secondary_oscillator_low_power_o, secondary_oscillator_ext_o;
  always #20 clk_i = ~clk_i;
  cwwp_top DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .nv_cw3_i(nv_cw3_i),
    .nv_cw4_i(nv_cw4_i),
    .cw3_prog_o(cw3_prog_o),
    .cw3_prog_data_o(cw3_prog_data_o),
    .fl_req_i(fl_req_i),
    .fl_addr_i(fl_addr_i),
    .fl_ok_o(fl_ok_o),
    .fl_reject_o(fl_reject_o),
    .reg_standby_en_i(reg_standby_en_i),
    .ready_o(ready_o),
    .pmp_default_map_o(pmp_default_map_o),
    .wake_fast_o(wake_fast_o),
    .secondary_oscillator_high_drive_o(secondary_oscillator_high_drive_o),
    .secondary_oscillator_low_power_o(secondary_oscillator_low_power_o),
    .secondary_oscillator_ext_o(secondary_oscillator_ext_o)
  );
  cwwp_fuse u_fuse (.clk_i(clk_i), .load_i(ld), .init_i(init),
    .prog_i(cw3_prog_o), .prog_data_i(cw3_prog_data_o),
    .cw3_o(nv_cw3_i), .cw4_o(nv_cw4_i));
  task end_of_test;
    begin
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task ck(input c);
    begin
      tests_run = tests_run + 1;
      if (c !== 1'h1) begin
        failures = failures + 1;
        $display("MISMATCH at %0t: value differs", $time);
      end
    end
  endtask
  // a wait that runs out is a failure
  task tmo(input integer n);
    begin
      if (n > 12) begin
        failures = failures + 1;
        end_of_test;
      end
    end
  endtask
  // classic cycle held until ack; data taken at that edge
  task wb(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'h1) begin
        n = n + 1;
        tmo(n);
        @(posedge clk_i);
      end
      rdat = wb_dat_o;
      pg = cw3_prog_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
      @(posedge clk_i);
    end
  endtask
  // one flash request, answer looked at the edge after
  task fl(input [23:0] a, input r);
    begin
      fl_req_i <= 1'h1;
      fl_addr_i <= a;
      @(posedge clk_i);
      fl_req_i <= 1'h0;
      @(posedge clk_i);
      ck(fl_reject_o === r && fl_ok_o === !r);
    end
  endtask
  // optional fresh image, reset, then decoded outputs
  task boot(input l, input [15:0] v);
    integer n;
    begin
      n = 0;
      ld <= l;
      init <= v;
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      ld <= 1'h0;
      rst_i <= 1'h0;
      fl(24'h020000, 1'h1);
      while (ready_o !== 1'h1) begin
        n = n + 1;
        tmo(n);
        @(posedge clk_i);
      end
      ck(pmp_default_map_o === v[12]);
      ck(wake_fast_o === (v[11:10] == 2'h1));
      ck({secondary_oscillator_high_drive_o, secondary_oscillator_low_power_o, secondary_oscillator_ext_o} ===
        {v[9:8] == 2'h3, v[9:8] == 2'h1, v[9:8] == 2'h0});
      wb(1'h0, 4'h0, 32'h0);
      ck(rdat === {16'h00FF, v});
    end
  endtask
  initial begin
    @(posedge clk_i);
    boot(1'h1, 16'hFFFF);
    fl(24'h03FC00, 1'h0);
    fl(24'h000000, 1'h0);
    wb(1'h0, 4'h4, 32'h0);
    ck(rdat === 32'h0000FFFF);
    wb(1'h0, 4'h2, 32'h0);
    ck(rdat === 32'h0);
    wb(1'h1, 4'h0, 32'h0000DF10);
    ck(pg === 1'h1 && cw3_prog_data_o === 16'hDF10);
    boot(1'h0, 16'hDF10);
    fl(24'h003C00, 1'h0);
    fl(24'h004000, 1'h1);
    fl(24'h03FC00, 1'h1);
    fl(24'h040000, 1'h0);
    wb(1'h1, 4'h0, 32'h0000FFFF);
    ck(pg === 1'h0);
    wb(1'h0, 4'h8, 32'h0);
    ck(rdat[0] === 1'h1 && rdat[3] === 1'h1);
    wb(1'h1, 4'hC, 32'h1);
    wb(1'h0, 4'h8, 32'h0);
    ck(rdat[0] === 1'h0);
    boot(1'h1, 16'h4510);
    fl(24'h000000, 1'h1);
    fl(24'h004000, 1'h1);
    fl(24'h004400, 1'h0);
    fl(24'h03FC00, 1'h0);
    reg_standby_en_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    ck(wake_fast_o === 1'h0);
    reg_standby_en_i <= 1'h1;
    boot(1'h1, 16'h1C10);
    fl(24'h03FC00, 1'h1);
    fl(24'h020000, 1'h0);
    boot(1'h1, 16'hF2FF);
    wb(1'h0, 4'h8, 32'h0);
    ck(rdat[2:1] === 2'h3 && rdat[4] === 1'h0);
    end_of_test;
  end
endmodule
